// file: hw/idma_pkg.sv
// constants and types shared by the indirect data-memory access block
`default_nettype none
package idma_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int unsigned IDMA_AXI_AW     = 10;
	localparam int unsigned IDMA_BYTE_SHIFT = 2;
	localparam int unsigned IDMA_NUM_BANKS  = 4;
	localparam logic [1:0]  IDMA_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  IDMA_RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// data-memory indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDMA_IDX_PORT0 = 8'h00;
	localparam logic [7:0] IDMA_IDX_PTR0  = 8'h01;
	localparam logic [7:0] IDMA_IDX_PORT1 = 8'h02;
	localparam logic [7:0] IDMA_IDX_PTR1  = 8'h03;
	localparam logic [7:0] IDMA_IDX_BANK  = 8'h04;
	localparam logic [7:0] IDMA_IDX_NVC   = 8'h40;
	localparam logic [7:0] IDMA_IDX_GP    = 8'h60;
	localparam int unsigned IDMA_NVC_BANK = 1;
	localparam int unsigned IDMA_GP_WORDS = 160;

	// ------------------------------------------------------------
	// reset and fixed values
	// ------------------------------------------------------------
	localparam logic [7:0] IDMA_PTR_RST  = 8'h00;
	localparam logic [7:0] IDMA_BANK_RST = 8'h00;
	localparam logic [7:0] IDMA_NVC_RST  = 8'h00;
	localparam logic [7:0] IDMA_SELF_VAL = 8'h00;

	// what a resolved access lands on
	typedef enum logic [2:0] {
		IDMA_K_SELF,
		IDMA_K_PTR0,
		IDMA_K_PTR1,
		IDMA_K_BANK,
		IDMA_K_NVC,
		IDMA_K_MEM,
		IDMA_K_ZERO,
		IDMA_K_NONE
	} idma_kind_e;

endpackage
`default_nettype wire

// file: hw/idma_ram.sv
// banked general-purpose data memory
`timescale 1ns/1ps
`default_nettype none
module idma_ram
	import idma_pkg::*;
#(
	parameter int unsigned NUM_BANKS = IDMA_NUM_BANKS,
	parameter int unsigned WORDS     = IDMA_GP_WORDS,
	parameter int unsigned BANK_W    = $clog2(NUM_BANKS)
) (
	input  wire logic              i_clock,
	input  wire logic              i_clk_en,
	input  wire logic              i_we,
	input  wire logic [BANK_W-1:0] i_wbank,
	input  wire logic [7:0]        i_waddr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic [BANK_W-1:0] i_rbank,
	input  wire logic [7:0]        i_raddr,
	output logic      [7:0]        o_rdata
);
	localparam int unsigned DEPTH = NUM_BANKS * WORDS;
	localparam int unsigned IW    = $clog2(DEPTH);

	// every gp address 60h..ffh of every bank needs a word
	if (NUM_BANKS < 2 || BANK_W != $clog2(NUM_BANKS) || WORDS < IDMA_GP_WORDS) begin : g_bad_geom
		$error("idma_ram: bank width or word count cannot cover the gp area");
	end

	logic [7:0] mem [DEPTH];

	// bank-major word index; reads also pass non-gp addresses, whose word is never used
	function automatic logic [IW-1:0] word_idx(input logic [BANK_W-1:0] b,
	                                           input logic [7:0] a);
		logic [7:0] off;
		off = a - IDMA_IDX_GP;
		return IW'(int'(b) * WORDS + int'(off));
	endfunction

	always_ff @(posedge i_clock) begin
		if (i_clk_en && i_we) begin
			mem[word_idx(i_wbank, i_waddr)] <= i_wdata;
		end
	end

	assign o_rdata = mem[word_idx(i_rbank, i_raddr)];

endmodule
`default_nettype wire

// file: hw/idma_regs.sv
// indirect data-memory access ports, pointers and bank select behind axi4-lite
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module idma_regs
	import idma_pkg::*;
#(
	parameter int unsigned NUM_BANKS = IDMA_NUM_BANKS
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_arst_n,
	input  wire logic                   i_clk_en,
	input  wire logic                   i_awvalid,
	output logic                        o_awready,
	input  wire logic [IDMA_AXI_AW-1:0] i_awaddr,
	input  wire logic                   i_wvalid,
	output logic                        o_wready,
	input  wire logic [31:0]            i_wdata,
	input  wire logic [3:0]             i_wstrb,
	output logic                        o_bvalid,
	input  wire logic                   i_bready,
	output logic      [1:0]             o_bresp,
	input  wire logic                   i_arvalid,
	output logic                        o_arready,
	input  wire logic [IDMA_AXI_AW-1:0] i_araddr,
	output logic                        o_rvalid,
	input  wire logic                   i_rready,
	output logic      [31:0]            o_rdata,
	output logic      [1:0]             o_rresp
);
	localparam int unsigned BANK_W = $clog2(NUM_BANKS);

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	if (NUM_BANKS != 2 && NUM_BANKS != 4) begin : g_bad_banks
		$error("idma_regs: NUM_BANKS must be 2 or 4");
	end

	typedef struct packed {
		idma_kind_e        kind;
		logic [BANK_W-1:0] bank;
		logic [7:0]        addr;
	} idma_tgt_s;

	// ------------------------------------------------------------
	// address resolution, shared by read and write paths
	// ------------------------------------------------------------
	function automatic idma_tgt_s resolve(input logic [7:0] a,
	                                      input logic [BANK_W-1:0] bk,
	                                      input logic [7:0] p0,
	                                      input logic [7:0] p1);
		idma_tgt_s t;
		logic      ind;
		t.addr = a;
		t.bank = bk;
		ind    = 1'b0;
		if (a == IDMA_IDX_PORT0) begin
			t.addr = p0;
			t.bank = '0;
			ind    = 1'b1;
		end else if (a == IDMA_IDX_PORT1) begin
			t.addr = p1;
			ind    = 1'b1;
		end
		if (t.addr == IDMA_IDX_PORT0 || t.addr == IDMA_IDX_PORT1) begin
			t.kind = IDMA_K_SELF;
		end else if (t.addr == IDMA_IDX_PTR0) begin
			t.kind = IDMA_K_PTR0;
		end else if (t.addr == IDMA_IDX_PTR1) begin
			t.kind = IDMA_K_PTR1;
		end else if (t.addr == IDMA_IDX_BANK) begin
			t.kind = IDMA_K_BANK;
		end else if (t.addr == IDMA_IDX_NVC) begin
			t.kind = (t.bank == BANK_W'(IDMA_NVC_BANK)) ? IDMA_K_NVC : IDMA_K_ZERO;
		end else if (t.addr >= IDMA_IDX_GP) begin
			t.kind = IDMA_K_MEM;
		end else begin
			t.kind = ind ? IDMA_K_ZERO : IDMA_K_NONE;
		end
		return t;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic              wr_rdy_q, wr_rdy_d;
	logic              bvalid_q, bvalid_d;
	logic [1:0]        bresp_q, bresp_d;
	logic              rd_rdy_q, rd_rdy_d;
	logic              rvalid_q, rvalid_d;
	logic [7:0]        rdata_q, rdata_d;
	logic [1:0]        rresp_q, rresp_d;
	logic [7:0]        ptr0_q, ptr0_d;
	logic [7:0]        ptr1_q, ptr1_d;
	logic [BANK_W-1:0] bank_q, bank_d;
	logic [7:0]        nvc_q, nvc_d;

	logic              wr_fire;
	logic              rd_fire;
	logic              wr_byte;
	logic              mem_we;
	logic [7:0]        mem_rdata;
	idma_tgt_s         wt;
	idma_tgt_s         rt;

	assign wr_fire = wr_rdy_q & i_awvalid & i_wvalid;
	assign rd_fire = rd_rdy_q & i_arvalid;
	assign wr_byte = i_wstrb[0];
	assign wt      = resolve(i_awaddr[IDMA_AXI_AW-1:IDMA_BYTE_SHIFT], bank_q, ptr0_q, ptr1_q);
	assign rt      = resolve(i_araddr[IDMA_AXI_AW-1:IDMA_BYTE_SHIFT], bank_q, ptr0_q, ptr1_q);
	assign mem_we  = wr_fire & wr_byte & (wt.kind == IDMA_K_MEM);

	// ------------------------------------------------------------
	// general-purpose memory
	// ------------------------------------------------------------
	idma_ram #(
		.NUM_BANKS (NUM_BANKS),
		.WORDS     (IDMA_GP_WORDS),
		.BANK_W    (BANK_W)
	) u_ram (
		.i_clock  (i_clock),
		.i_clk_en (i_clk_en),
		.i_we     (mem_we),
		.i_wbank  (wt.bank),
		.i_waddr  (wt.addr),
		.i_wdata  (i_wdata[7:0]),
		.i_rbank  (rt.bank),
		.i_raddr  (rt.addr),
		.o_rdata  (mem_rdata)
	);

	// ------------------------------------------------------------
	// write channel: address and data taken together, one in flight
	// ------------------------------------------------------------
	always_comb begin
		wr_rdy_d = 1'b0;
		bvalid_d = bvalid_q & ~i_bready;
		bresp_d  = bresp_q;
		if (!wr_rdy_q && !bvalid_q && i_awvalid && i_wvalid) begin
			wr_rdy_d = 1'b1;
		end
		if (wr_fire) begin
			bvalid_d = 1'b1;
			bresp_d  = (wt.kind == IDMA_K_NONE) ? IDMA_RESP_SLVERR : IDMA_RESP_OKAY;
		end
	end

	// ------------------------------------------------------------
	// register updates; self-targeted and zero kinds drop the write
	// ------------------------------------------------------------
	always_comb begin
		ptr0_d = ptr0_q;
		ptr1_d = ptr1_q;
		bank_d = bank_q;
		nvc_d  = nvc_q;
		if (wr_fire && wr_byte) begin
			unique case (wt.kind)
				IDMA_K_PTR0: ptr0_d = i_wdata[7:0];
				IDMA_K_PTR1: ptr1_d = i_wdata[7:0];
				IDMA_K_BANK: bank_d = i_wdata[BANK_W-1:0];
				IDMA_K_NVC:  nvc_d  = i_wdata[7:0];
				IDMA_K_SELF, IDMA_K_MEM, IDMA_K_ZERO, IDMA_K_NONE: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	always_comb begin
		rd_rdy_d = 1'b0;
		rvalid_d = rvalid_q & ~i_rready;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (!rd_rdy_q && !rvalid_q && i_arvalid) begin
			rd_rdy_d = 1'b1;
		end
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rresp_d  = (rt.kind == IDMA_K_NONE) ? IDMA_RESP_SLVERR : IDMA_RESP_OKAY;
			unique case (rt.kind)
				IDMA_K_SELF: rdata_d = IDMA_SELF_VAL;
				IDMA_K_PTR0: rdata_d = ptr0_q;
				IDMA_K_PTR1: rdata_d = ptr1_q;
				IDMA_K_BANK: rdata_d = 8'(bank_q);
				IDMA_K_NVC:  rdata_d = nvc_q;
				IDMA_K_MEM:  rdata_d = mem_rdata;
				IDMA_K_ZERO, IDMA_K_NONE: rdata_d = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers, frozen while the clock enable is low
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_rdy_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= IDMA_RESP_OKAY;
			rd_rdy_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q  <= 8'h00;
			rresp_q  <= IDMA_RESP_OKAY;
			ptr0_q   <= IDMA_PTR_RST;
			ptr1_q   <= IDMA_PTR_RST;
			bank_q   <= IDMA_BANK_RST[BANK_W-1:0];
			nvc_q    <= IDMA_NVC_RST;
		end else if (i_clk_en) begin
			wr_rdy_q <= wr_rdy_d;
			bvalid_q <= bvalid_d;
			bresp_q  <= bresp_d;
			rd_rdy_q <= rd_rdy_d;
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
			ptr0_q   <= ptr0_d;
			ptr1_q   <= ptr1_d;
			bank_q   <= bank_d;
			nvc_q    <= nvc_d;
		end
	end

	assign o_awready = wr_rdy_q;
	assign o_wready  = wr_rdy_q;
	assign o_bvalid  = bvalid_q;
	assign o_bresp   = bresp_q;
	assign o_arready = rd_rdy_q;
	assign o_rvalid  = rvalid_q;
	assign o_rdata   = {24'h000000, rdata_q};
	assign o_rresp   = rresp_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_port0_target: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
		wr_fire && wr_byte && i_awaddr[IDMA_AXI_AW-1:2] == IDMA_IDX_PORT0
			&& ptr0_q >= IDMA_IDX_GP |-> mem_we && wt.addr == ptr0_q)
		else $error("port zero write did not reach its pointer location");

	a_port0_bank_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
		wr_fire && i_awaddr[IDMA_AXI_AW-1:2] == IDMA_IDX_PORT0 |-> wt.bank == '0)
		else $error("port zero left bank 0");

	a_port1_bank_sel: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
		rd_fire && i_araddr[IDMA_AXI_AW-1:2] == IDMA_IDX_PORT1
			&& ptr1_q >= IDMA_IDX_GP |-> rt.bank == bank_q && rt.addr == ptr1_q)
		else $error("port one did not use bank select");

	a_self_read_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
		rd_fire && rt.kind == IDMA_K_SELF |=> o_rvalid && o_rdata == 32'h00000000)
		else $error("self-targeted indirect read not zero");

	a_self_write_drop: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
		wr_fire && wt.kind == IDMA_K_SELF |-> !mem_we ##1
			$stable(ptr0_q) && $stable(ptr1_q) && $stable(bank_q) && $stable(nvc_q))
		else $error("self-targeted indirect write changed state");

	a_bank_write: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
		wr_fire && wr_byte && wt.kind == IDMA_K_BANK
			|=> bank_q == $past(i_wdata[BANK_W-1:0]))
		else $error("bank select not loaded");

	a_nvc_bank_one: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
		rd_fire && i_araddr[IDMA_AXI_AW-1:2] == IDMA_IDX_NVC
			&& bank_q != BANK_W'(IDMA_NVC_BANK) |=> o_rdata == 32'h00000000)
		else $error("control register answered outside bank 1");

	a_read_latency: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
		i_clk_en && i_arvalid && !o_rvalid |-> ##[1:2] o_rvalid)
		else $error("read answer late");

	a_write_latency: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
		i_clk_en && i_awvalid && i_wvalid && !o_bvalid |-> ##[1:2] o_bvalid)
		else $error("write answer late");

	a_nvc_load: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
		i_clk_en && wr_fire && wr_byte && wt.kind == IDMA_K_NVC
			|=> nvc_q == $past(i_wdata[7:0]))
		else $error("control register not loaded in bank 1");

	a_port1_data: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
		i_clk_en && rd_fire && i_araddr[IDMA_AXI_AW-1:2] == IDMA_IDX_PORT1
			&& rt.kind == IDMA_K_MEM |=> o_rdata[7:0] == $past(mem_rdata))
		else $error("port one read did not return its pointer location");

	// a low clock enable must hold handshakes and registers where they are
	a_freeze_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		!i_clk_en |=> $stable(wr_rdy_q) && $stable(rd_rdy_q) && $stable(bvalid_q)
			&& $stable(rvalid_q) && $stable(ptr0_q) && $stable(bank_q))
		else $error("state moved while the clock enable was low");

endmodule
`default_nettype wire

// file: sim/idma_cpu.sv
// cpu-side axi4-lite master that issues data-memory accesses
`timescale 1ns/1ps
`default_nettype none
module idma_cpu (
	input  wire logic        i_clock,
	output logic             o_awvalid,
	input  wire logic        i_awready,
	output logic      [9:0]  o_awaddr,
	output logic             o_wvalid,
	input  wire logic        i_wready,
	output logic      [31:0] o_wdata,
	output logic      [3:0]  o_wstrb,
	input  wire logic        i_bvalid,
	output logic             o_bready,
	output logic             o_arvalid,
	input  wire logic        i_arready,
	output logic      [9:0]  o_araddr,
	input  wire logic        i_rvalid,
	output logic             o_rready
);
	initial {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_awaddr, o_araddr,
		o_wdata, o_wstrb} <= '0;

	// callers aim one write at reserved index 05h, which answers SLVERR
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done  = 1'b0;
		o_awvalid <= 1'b1;
		o_wvalid <= 1'b1;
		o_awaddr <= a;
		o_wdata <= {24'h0, d};
		o_wstrb <= 4'h1;
		o_bready <= 1'b1;
		// each channel lets go at its own ready; released lines stop showing the payload
		do begin
			@(posedge i_clock);
			if (!aw_done && i_awready === 1'b1) begin
				aw_done = 1'b1;
				o_awvalid <= 1'b0;
				o_awaddr <= ~a;
			end
			if (!w_done && i_wready === 1'b1) begin
				w_done = 1'b1;
				o_wvalid <= 1'b0;
				o_wdata <= ~{24'h0, d};
			end
		end while (!(aw_done && w_done));
		while (i_bvalid !== 1'b1) @(posedge i_clock);
		o_bready <= 1'b0;
		@(posedge i_clock);
	endtask

	task automatic rd(input logic [9:0] a);
		o_arvalid <= 1'b1;
		o_araddr <= a;
		o_rready <= 1'b1;
		do @(posedge i_clock); while (i_arready !== 1'b1);
		o_arvalid <= 1'b0;
		o_araddr <= ~a;
		while (i_rvalid !== 1'b1) @(posedge i_clock);
		o_rready <= 1'b0;
		@(posedge i_clock);
	endtask
endmodule
`default_nettype wire

// file: sim/indirect_data_memory_access_tb.sv
// self-checking bench for the indirect data-memory access block
`timescale 1ns/1ps
`default_nettype none
module indirect_data_memory_access_tb;
	import idma_pkg::*;
	logic        i_clock, i_arst_n, i_clk_en, i_awvalid, o_awready, i_wvalid, o_wready;
	logic        o_bvalid, i_bready, i_arvalid, o_arready, o_rvalid, i_rready;
	logic [9:0]  i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0]  i_wstrb;
	logic [1:0]  o_bresp, o_rresp;
	logic [33:0] exp_q[$];
	logic [7:0]  d0, d1, d2;
	int          failures, cmp_count, cyc, seed;

	idma_regs uut (.i_clock, .i_arst_n, .i_clk_en, .i_awvalid, .o_awready, .i_awaddr,
		.i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
		.i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp);

	idma_cpu cpu (.i_clock, .o_awvalid(i_awvalid), .i_awready(o_awready),
		.o_awaddr(i_awaddr), .o_wvalid(i_wvalid), .i_wready(o_wready), .o_wdata(i_wdata),
		.o_wstrb(i_wstrb), .i_bvalid(o_bvalid), .o_bready(i_bready),
		.o_arvalid(i_arvalid), .i_arready(o_arready), .o_araddr(i_araddr),
		.i_rvalid(o_rvalid), .o_rready(i_rready));

	// ------------------------------------------------------------
	// checking
	// ------------------------------------------------------------
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (exp_q.size() != 0)
			failures++;
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge i_clock) begin
		if ((o_bvalid & i_bready) === 1'b1)
			check({o_bresp, 32'h0}, exp_q.pop_front());
		if ((o_rvalid & i_rready) === 1'b1)
			check({o_rresp, o_rdata}, exp_q.pop_front());
	end

	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			print_verdict();
		end
	end

	// ------------------------------------------------------------
	// stimulus
	// ------------------------------------------------------------
	task automatic w(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] rs);
		exp_q.push_back({rs, 32'h0});
		cpu.wr({ix, 2'b00}, d);
	endtask

	task automatic r(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] rs);
		exp_q.push_back({rs, 24'h0, d});
		cpu.rd({ix, 2'b00});
	endtask

	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end

	initial begin
		i_arst_n = 1'b0;
		i_clk_en = 1'b1;
		seed = 74;
		// low bits keep the three data bytes distinct and nonzero
		d0 = 8'($random(seed)) | 8'h03;
		d1 = (8'($random(seed)) & 8'hfc) | 8'h01;
		d2 = (8'($random(seed)) & 8'hfc) | 8'h02;
		repeat (20) @(posedge i_clock);
		i_arst_n <= 1'b1;
		@(posedge i_clock);
		r(IDMA_IDX_PTR0, IDMA_PTR_RST, IDMA_RESP_OKAY);
		r(IDMA_IDX_PTR1, IDMA_PTR_RST, IDMA_RESP_OKAY);
		r(IDMA_IDX_BANK, IDMA_BANK_RST, IDMA_RESP_OKAY);
		r(8'h05, 8'h00, IDMA_RESP_SLVERR);
		w(IDMA_IDX_PTR0, IDMA_IDX_GP, IDMA_RESP_OKAY);
		w(IDMA_IDX_PTR1, IDMA_IDX_GP, IDMA_RESP_OKAY);
		w(IDMA_IDX_BANK, 8'h02, IDMA_RESP_OKAY);
		w(IDMA_IDX_PORT0, d0, IDMA_RESP_OKAY);
		w(IDMA_IDX_PORT1, d1, IDMA_RESP_OKAY);
		r(IDMA_IDX_PORT0, d0, IDMA_RESP_OKAY);
		r(IDMA_IDX_PORT1, d1, IDMA_RESP_OKAY);
		r(IDMA_IDX_GP, d1, IDMA_RESP_OKAY);
		w(IDMA_IDX_BANK, 8'h00, IDMA_RESP_OKAY);
		r(IDMA_IDX_GP, d0, IDMA_RESP_OKAY);
		r(IDMA_IDX_PORT1, d0, IDMA_RESP_OKAY);
		w(IDMA_IDX_GP, d2, IDMA_RESP_OKAY);
		r(IDMA_IDX_PORT0, d2, IDMA_RESP_OKAY);
		w(IDMA_IDX_PTR0, IDMA_IDX_PORT1, IDMA_RESP_OKAY);
		r(IDMA_IDX_PORT0, IDMA_SELF_VAL, IDMA_RESP_OKAY);
		w(IDMA_IDX_PORT0, d1, IDMA_RESP_OKAY);
		w(IDMA_IDX_PTR1, IDMA_IDX_PORT0, IDMA_RESP_OKAY);
		r(IDMA_IDX_PORT1, IDMA_SELF_VAL, IDMA_RESP_OKAY);
		w(IDMA_IDX_PORT1, d1, IDMA_RESP_OKAY);
		r(IDMA_IDX_PTR0, IDMA_IDX_PORT1, IDMA_RESP_OKAY);
		r(IDMA_IDX_PTR1, IDMA_IDX_PORT0, IDMA_RESP_OKAY);
		r(IDMA_IDX_GP, d2, IDMA_RESP_OKAY);
		w(IDMA_IDX_PTR1, IDMA_IDX_PTR0, IDMA_RESP_OKAY);
		w(IDMA_IDX_PORT1, IDMA_IDX_GP, IDMA_RESP_OKAY);
		r(IDMA_IDX_PTR0, IDMA_IDX_GP, IDMA_RESP_OKAY);
		w(IDMA_IDX_BANK, 8'h01, IDMA_RESP_OKAY);
		w(IDMA_IDX_NVC, d0, IDMA_RESP_OKAY);
		r(IDMA_IDX_NVC, d0, IDMA_RESP_OKAY);
		w(IDMA_IDX_BANK, 8'hff, IDMA_RESP_OKAY);
		r(IDMA_IDX_BANK, 8'h03, IDMA_RESP_OKAY);
		r(IDMA_IDX_NVC, 8'h00, IDMA_RESP_OKAY);
		w(IDMA_IDX_NVC, d1, IDMA_RESP_OKAY);
		r(IDMA_IDX_PTR0, IDMA_IDX_GP, IDMA_RESP_OKAY);
		w(IDMA_IDX_BANK, 8'h01, IDMA_RESP_OKAY);
		r(IDMA_IDX_NVC, d0, IDMA_RESP_OKAY);
		w(IDMA_IDX_PTR0, IDMA_IDX_NVC, IDMA_RESP_OKAY);
		r(IDMA_IDX_PORT0, 8'h00, IDMA_RESP_OKAY);
		w(8'h05, d2, IDMA_RESP_SLVERR);
		// a read offered while the clock enable is low must wait for it
		i_clk_en <= 1'b0;
		fork
			r(IDMA_IDX_PTR0, IDMA_IDX_NVC, IDMA_RESP_OKAY);
			begin
				repeat (5) @(posedge i_clock);
				i_clk_en <= 1'b1;
			end
		join
		// reset in mid-run: registers return, memory keeps its words
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_arst_n <= 1'b1;
		@(posedge i_clock);
		r(IDMA_IDX_PTR0, IDMA_PTR_RST, IDMA_RESP_OKAY);
		r(IDMA_IDX_BANK, IDMA_BANK_RST, IDMA_RESP_OKAY);
		r(IDMA_IDX_GP, d2, IDMA_RESP_OKAY);
		w(IDMA_IDX_BANK, 8'h01, IDMA_RESP_OKAY);
		r(IDMA_IDX_NVC, IDMA_NVC_RST, IDMA_RESP_OKAY);
		repeat (4) @(posedge i_clock);
		print_verdict();
	end
endmodule
`default_nettype wire
